/* hw/aps_top.sv */
// protection supervisor for a two-channel switching amplifier
`timescale 1ns/100ps
// Overview of operation
// RULE_01 - start-up from standby stalls while an output is shorted
// RULE_02 - short check runs with power stages still disabled
// RULE_03 - restart after overcurrent shutdown reruns the short check
// RULE_04 - undervoltage shuts all down; restart 100 ms after it clears
// RULE_05 - overvoltage disables power stages; restart 100 ms after it clears
// RULE_06 - supply imbalance shuts down; restart 100 ms after it clears
// RULE_07 - clock loss switches amplifier off until clock back, then 100 ms
// RULE_08 - warning before foldback; foldback never shuts down or flags
// RULE_09 - all protections but foldback flag fault status; most restart late
// RULE_10 - only overcurrent drains capacitor; shutdown only on low impedance
// RULE_11 - window fault never shuts down; start-up resumes once clear
// RULE_12 - fault status held while off and during start-up, at least 100 ms
// RULE_13 - overcurrent restart retried every 100 ms until current normal
// RULE_14 - overtemp restart about 100 ms after temperature falls
// RULE_15 - controller selects one of four modes on the mode pin
// RULE_16 - one shared restart timer; any new fault restarts it (here only overtemp, voltage, imbalance and clock loss do)
// RULE_17 - every asynchronous fault input passes a two-stage synchroniser
module aps_top #(
  parameter logic [aps_pkg::TMR_W-1:0] RESTART_CYCLES =
    aps_pkg::TMR_W'(aps_pkg::RESTART_CYCLES)
) (
  // clock, reset, enable
  input wire logic I_CORE_CLK,
  input wire logic I_RST_N,
  input wire logic I_CE,
  // mode from controller
  input wire logic [1:0] I_MODE,
  // asynchronous fault indications
  input wire logic I_OVERTEMP,
  input wire logic I_UNDERVOLT,
  input wire logic I_OVERVOLT,
  input wire logic I_IMBALANCE,
  input wire logic I_CLOCK_LOSS,
  input wire logic I_OC_LIMIT,
  input wire logic I_OC_LOW_Z,
  input wire logic I_WINDOW_SHORT,
  input wire logic I_TEMP_WARN,
  input wire logic I_TEMP_FOLD,
  // output stage control
  output logic O_POWER_EN,
  output logic O_MUTE,
  output logic O_FOLDBACK_EN,
  output logic O_CAP_DISCHARGE,
  // open-drain diagnostic pins, low when driven
  input wire logic I_THERMAL_WARNING,
  output logic O_THERMAL_WARNING,
  output logic O_THERMAL_WARNING_OE,
  input wire logic I_FAULT_STATUS,
  output logic O_FAULT_STATUS,
  output logic O_FAULT_STATUS_OE,
  // register port
  input wire logic [3:0] I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [31:0] O_RDATA,
  // interrupt
  output logic O_IRQ
);
  localparam int NF = 10;

  logic [NF-1:0] raw;
  logic [NF-1:0] syn;
  logic [1:0] mode_s;
  logic otp;
  logic uvp;
  logic ovp;
  logic ubp;
  logic clk_loss;
  logic oc_limit;
  logic oc_low_z;
  logic wp_short;
  logic warn;
  logic fold;
  aps_pkg::aps_state_t state;
  aps_pkg::aps_state_t next_state;
  logic [aps_pkg::CAP_W-1:0] cap_level;
  logic cap_empty;
  logic oc_restart;
  logic hard_fault;
  logic timer_done;
  logic force_stby;
  logic [31:0] ctrl;
  logic [aps_pkg::NUM_EV-1:0] ev_status;
  logic [aps_pkg::NUM_EV-1:0] ev_mask;
  logic [aps_pkg::NUM_EV-1:0] ev_now;
  logic [aps_pkg::NUM_EV-1:0] ev_prev;
  logic [aps_pkg::NUM_EV-1:0] ev_set;
  logic wr_ev;
  logic fault_diag;

  // ==========================================
  // input synchronisers
  assign raw = {I_TEMP_FOLD, I_TEMP_WARN, I_WINDOW_SHORT, I_OC_LOW_Z,
                I_OC_LIMIT, I_CLOCK_LOSS, I_IMBALANCE, I_OVERVOLT,
                I_UNDERVOLT, I_OVERTEMP};

  // RULE_17 synchronise fault inputs
  aps_sync #(.W(NF)) u_sync_fault (
    .i_clk(I_CORE_CLK),
    .i_rst_n(I_RST_N),
    .i_ce(I_CE),
    .i_async(raw),
    .o_sync(syn)
  );

  // mode pin is taken as synchronous
  assign mode_s = I_MODE;
  assign otp = syn[0];
  assign uvp = syn[1];
  assign ovp = syn[2];
  assign ubp = syn[3];
  assign clk_loss = syn[4];
  assign oc_limit = syn[5];
  assign oc_low_z = syn[6];
  assign wp_short = syn[7];
  assign warn = syn[8];
  assign fold = syn[9];

  // ==========================================
  // short timer capacitor model
  function automatic logic is_running(input aps_pkg::aps_state_t s);
    is_running = (s == aps_pkg::ST_MUTE) || (s == aps_pkg::ST_OPERATE);
  endfunction

  // RULE_10 drain only on low-impedance limiting
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      cap_level <= aps_pkg::CAP_W'(aps_pkg::CAP_DRAIN_CYCLES);
    else if (I_CE)
    begin
      if (!is_running(state))
        cap_level <= aps_pkg::CAP_W'(aps_pkg::CAP_DRAIN_CYCLES);
      else if (oc_limit && oc_low_z && cap_level != '0)
        cap_level <= cap_level - 1'b1;
      else if (!(oc_limit && oc_low_z))
        cap_level <= aps_pkg::CAP_W'(aps_pkg::CAP_DRAIN_CYCLES);
    end
  end

  // recharge on a clean cycle keeps brief impedance dips from tripping
  assign cap_empty = is_running(state) && (cap_level == '0);
  // RULE_10 discharge output only from overcurrent
  assign O_CAP_DISCHARGE = is_running(state) && oc_limit && oc_low_z;

  // ==========================================
  // shared restart timer
  // RULE_09 faults that force complete shutdown
  assign hard_fault = otp || uvp || ovp || ubp || clk_loss;

  // RULE_16 one timer, held by any pending hard fault (not overcurrent or window short)
  aps_restart_timer #(.CYCLES(RESTART_CYCLES)) u_restart (
    .i_clk(I_CORE_CLK),
    .i_rst_n(I_RST_N),
    .i_ce(I_CE),
    .i_hold(hard_fault),
    .i_run(state == aps_pkg::ST_SHUTDOWN),
    .o_done(timer_done)
  );

  // ==========================================
  // supervisor state machine
  assign force_stby = ctrl[aps_pkg::CTRL_FORCE_STBY];

  always_comb
  begin
    next_state = state;
    unique case (state)
      aps_pkg::ST_STANDBY:
      begin
        if (hard_fault)
          next_state = aps_pkg::ST_SHUTDOWN;
        else if (mode_s != aps_pkg::MODE_STANDBY && !force_stby)
          // RULE_02 check before power stages enable
          next_state = aps_pkg::ST_WINDOW;
      end
      aps_pkg::ST_WINDOW:
      begin
        if (hard_fault)
          next_state = aps_pkg::ST_SHUTDOWN;
        else if (mode_s == aps_pkg::MODE_STANDBY || force_stby)
          next_state = aps_pkg::ST_STANDBY;
        // RULE_01 stall while shorted
        // RULE_11 resume directly once clear
        else if (!wp_short)
          next_state = (mode_s == aps_pkg::MODE_MUTE) ?
                       aps_pkg::ST_MUTE : aps_pkg::ST_OPERATE;
      end
      aps_pkg::ST_MUTE,
      aps_pkg::ST_OPERATE:
      begin
        // RULE_04 RULE_05 RULE_06 RULE_07 shut down on fault
        // RULE_10 full shutdown when capacitor drained
        if (hard_fault || cap_empty)
          next_state = aps_pkg::ST_SHUTDOWN;
        else if (mode_s == aps_pkg::MODE_STANDBY || force_stby)
          next_state = aps_pkg::ST_STANDBY;
        else if (mode_s == aps_pkg::MODE_MUTE)
          next_state = aps_pkg::ST_MUTE;
        else
          next_state = aps_pkg::ST_OPERATE;
      end
      aps_pkg::ST_SHUTDOWN:
      begin
        // RULE_14 restart delayed after fault clears
        if (timer_done)
        begin
          if (mode_s == aps_pkg::MODE_STANDBY || force_stby)
            next_state = aps_pkg::ST_STANDBY;
          // RULE_03 short check on overcurrent restart
          // RULE_13 retries every 100 ms via recharge
          else if (oc_restart)
            next_state = aps_pkg::ST_WINDOW;
          else
            next_state = (mode_s == aps_pkg::MODE_MUTE) ?
                         aps_pkg::ST_MUTE : aps_pkg::ST_OPERATE;
        end
      end
      default:
        next_state = aps_pkg::ST_SHUTDOWN;
    endcase
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      state <= aps_pkg::ST_STANDBY;
    else if (I_CE)
      state <= next_state;
  end

  // RULE_03 remember an overcurrent shutdown
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      oc_restart <= 1'b0;
    else if (I_CE)
    begin
      if (is_running(state) && cap_empty)
        oc_restart <= 1'b1;
      else if (is_running(state) || state == aps_pkg::ST_STANDBY)
        oc_restart <= 1'b0;
    end
  end

  // ==========================================
  // output stage and diagnostics
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      O_POWER_EN <= 1'b0;
      O_MUTE <= 1'b1;
      O_FOLDBACK_EN <= 1'b0;
    end
    else if (I_CE)
    begin
      O_POWER_EN <= is_running(next_state);
      O_MUTE <= next_state != aps_pkg::ST_OPERATE;
      // RULE_08 foldback only limits gain
      O_FOLDBACK_EN <= fold && is_running(next_state) &&
                       mode_s != aps_pkg::MODE_OPERATE_NO_FOLD;
    end
  end

  // RULE_12 held through shutdown and start-up
  // RULE_09 every protection except foldback
  assign fault_diag = state == aps_pkg::ST_SHUTDOWN ||
                      state == aps_pkg::ST_WINDOW ||
                      (is_running(state) && oc_limit);

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      O_FAULT_STATUS_OE <= 1'b0;
      O_THERMAL_WARNING_OE <= 1'b0;
    end
    else if (I_CE)
    begin
      O_FAULT_STATUS_OE <= fault_diag;
      // RULE_08 warning even with foldback disabled
      O_THERMAL_WARNING_OE <= warn;
    end
  end

  // pins only ever pull low; readback inputs go to the state register
  assign O_FAULT_STATUS = 1'b0;
  assign O_THERMAL_WARNING = 1'b0;

  // ==========================================
  // events and interrupt
  assign ev_now = {warn, wp_short && state == aps_pkg::ST_WINDOW,
                   cap_empty, clk_loss, ubp, ovp, uvp, otp};
  assign ev_set = ev_now & ~ev_prev;
  assign wr_ev = I_WR && I_ADDR == aps_pkg::ADDR_EVENT;

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      ev_prev <= '0;
    else if (I_CE)
      ev_prev <= ev_now;
  end

  // set wins over a same-cycle write-one clear
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      ev_status <= '0;
    else if (I_CE)
      ev_status <= (ev_status & ~(wr_ev ? I_WDATA[aps_pkg::NUM_EV-1:0] :
                    '0)) | ev_set;
  end

  assign O_IRQ = |(ev_status & ev_mask);

  // ==========================================
  // register port
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      ctrl <= aps_pkg::CTRL_RESET;
      ev_mask <= aps_pkg::MASK_RESET;
    end
    else if (I_CE && I_WR)
    begin
      if (I_ADDR == aps_pkg::ADDR_CTRL)
        ctrl <= {31'h0000_0000, I_WDATA[aps_pkg::CTRL_FORCE_STBY]};
      if (I_ADDR == aps_pkg::ADDR_MASK)
        ev_mask <= I_WDATA[aps_pkg::NUM_EV-1:0];
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      O_RDATA <= 32'h0000_0000;
    else if (I_CE)
    begin
      O_RDATA <= 32'h0000_0000;
      if (I_RD)
      begin
        unique case (I_ADDR)
          aps_pkg::ADDR_CTRL: O_RDATA <= ctrl;
          aps_pkg::ADDR_EVENT: O_RDATA <= {24'h00_0000, ev_status};
          aps_pkg::ADDR_MASK: O_RDATA <= {24'h00_0000, ev_mask};
          aps_pkg::ADDR_STATE:
            O_RDATA <= {8'h00, ~I_FAULT_STATUS, ~I_THERMAL_WARNING,
                        oc_restart, state, 6'h00, syn};
          default: O_RDATA <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule

/* hw/aps_pkg.sv */
// shared constants for the amplifier protection supervisor
package aps_pkg;
  // ==========================================
  // clock and timing
  localparam int CLK_FREQ_KHZ = 200000;
  localparam int RESTART_TIME_MS = 100;
  localparam int RESTART_CYCLES = RESTART_TIME_MS * CLK_FREQ_KHZ;
  // cycles of low-impedance limiting that drain the short timer capacitor
  localparam int CAP_DRAIN_CYCLES = 64;
  localparam int TMR_W = 25;
  localparam int CAP_W = 7;
  // ==========================================
  // register map
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_EVENT = 4'h4;
  localparam logic [3:0] ADDR_MASK = 4'h8;
  localparam logic [3:0] ADDR_STATE = 4'hc;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam int CTRL_FORCE_STBY = 0;
  // ==========================================
  // event bit positions
  localparam int EV_OVERTEMP = 0;
  localparam int EV_UNDERVOLT = 1;
  localparam int EV_OVERVOLT = 2;
  localparam int EV_IMBALANCE = 3;
  localparam int EV_CLOCK_LOSS = 4;
  localparam int EV_OC_SHUT = 5;
  localparam int EV_WINDOW = 6;
  localparam int EV_WARN = 7;
  localparam int NUM_EV = 8;
  // ==========================================
  // mode input codes
  localparam logic [1:0] MODE_STANDBY = 2'h0;
  localparam logic [1:0] MODE_MUTE = 2'h1;
  localparam logic [1:0] MODE_OPERATE = 2'h2;
  localparam logic [1:0] MODE_OPERATE_NO_FOLD = 2'h3;
  // ==========================================
  // supervisor states
  typedef enum logic [4:0] {
    ST_STANDBY  = 5'b00001,
    ST_WINDOW   = 5'b00010,
    ST_MUTE     = 5'b00100,
    ST_OPERATE  = 5'b01000,
    ST_SHUTDOWN = 5'b10000
  } aps_state_t;
endpackage

/* hw/aps_sync.sv */
// two-stage synchroniser for a group of asynchronous levels
`timescale 1ns/100ps
module aps_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // levels
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] stage1;

  // ==========================================
  // first stage feeds only the second
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      stage1 <= '0;
      o_sync <= '0;
    end
    else if (i_ce)
    begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end
endmodule

/* hw/aps_restart_timer.sv */
// shared restart delay timer, restarted by any pending hard fault
`timescale 1ns/100ps
module aps_restart_timer #(
  parameter logic [aps_pkg::TMR_W-1:0] CYCLES =
    aps_pkg::TMR_W'(aps_pkg::RESTART_CYCLES)
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // control
  input wire logic i_hold,
  input wire logic i_run,
  output logic o_done
);
  logic [aps_pkg::TMR_W-1:0] count;

  // ==========================================
  // count up while running; a fault holds it at zero
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      count <= '0;
    else if (i_ce)
    begin
      if (i_hold || !i_run)
        count <= '0;
      else if (count != CYCLES)
        count <= count + 1'b1;
    end
  end

  assign o_done = i_run && !i_hold && (count == CYCLES);
endmodule

/* dv/aps_monitor.sv */
// port checker for the amplifier protection supervisor
`timescale 1ns/100ps
module aps_monitor #(
  parameter logic [aps_pkg::TMR_W-1:0] RESTART_CYCLES = 25'h000_0032
) (
  // clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_RST_N,
  // watched inputs
  input wire logic [1:0] I_MODE,
  input wire logic I_OVERTEMP,
  input wire logic I_UNDERVOLT,
  input wire logic I_OVERVOLT,
  input wire logic I_IMBALANCE,
  input wire logic I_CLOCK_LOSS,
  input wire logic I_OC_LIMIT,
  input wire logic I_OC_LOW_Z,
  input wire logic I_WINDOW_SHORT,
  input wire logic I_TEMP_WARN,
  // watched outputs
  input wire logic O_POWER_EN,
  input wire logic O_CAP_DISCHARGE,
  input wire logic O_THERMAL_WARNING_OE,
  input wire logic O_FAULT_STATUS_OE
);
  localparam int W = aps_pkg::TMR_W;
  logic hard;
  logic pend;
  logic [W-1:0] hq, aq;
  logic [6:0] cap_run;
  assign hard = I_OVERTEMP | I_UNDERVOLT | I_OVERVOLT | I_IMBALANCE |
    I_CLOCK_LOSS;
  // ======
  // quiet counters saturate so long idle spans never wrap
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      hq <= '1;
      aq <= '1;
      cap_run <= 7'h0;
      pend <= 1'b0;
    end
    else
    begin
      hq <= hard ? '0 : hq + W'(~&hq);
      aq <= (hard | I_OC_LIMIT | I_WINDOW_SHORT) ? '0 : aq + W'(~&aq);
      cap_run <= O_CAP_DISCHARGE ? cap_run + 7'(~&cap_run) : 7'h0;
      if (hard && O_POWER_EN)
        pend <= 1'b1;
      else if (O_POWER_EN)
        pend <= 1'b0;
    end
  end
  // ======
  // assertions
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RST_N);
  a_hard_off: assert property (
    (O_POWER_EN && hard) ##1 hard[*5] |-> !O_POWER_EN && O_FAULT_STATUS_OE)
    else $error("hard fault did not shut down and flag");
  a_restart_wait: assert property (
    $rose(O_POWER_EN) && pend |-> hq > RESTART_CYCLES)
    else $error("restart before the delay ran out");
  a_restart_late: assert property (
    pend && aq == RESTART_CYCLES + W'(4'ha) && I_MODE[1] |-> O_POWER_EN)
    else $error("restart missing after the delay");
  a_run_clean: assert property (
    O_POWER_EN && $past(O_POWER_EN) && aq > W'(4'h4)
      |-> !O_FAULT_STATUS_OE && !O_CAP_DISCHARGE)
    else $error("fault flag or discharge while running clean");
  a_fold_keep: assert property (
    O_POWER_EN && aq > W'(4'h4) && I_MODE == $past(I_MODE) |=> O_POWER_EN)
    else $error("power dropped with no fault");
  a_warn_follow: assert property (
    I_TEMP_WARN[*5] |-> O_THERMAL_WARNING_OE)
    else $error("thermal warning not shown");
  a_cap_cause: assert property (
    O_CAP_DISCHARGE |-> $past(I_OC_LIMIT, 2) && $past(I_OC_LOW_Z, 2))
    else $error("discharge without low impedance limiting");
  a_oc_shut: assert property (
    cap_run == 7'h40 |-> ##[1:6] !O_POWER_EN)
    else $error("no shutdown after drained capacitor");
  a_window_start: assert property (
    $rose(O_POWER_EN)
      |-> !($past(I_WINDOW_SHORT, 2) && $past(I_WINDOW_SHORT, 3)))
    else $error("power enabled with output shorted");
endmodule
bind aps_top aps_monitor #(.RESTART_CYCLES(RESTART_CYCLES)) aps_monitor_i (
  .I_CORE_CLK(I_CORE_CLK), .I_RST_N(I_RST_N), .I_MODE(I_MODE),
  .I_OVERTEMP(I_OVERTEMP), .I_UNDERVOLT(I_UNDERVOLT),
  .I_OVERVOLT(I_OVERVOLT), .I_IMBALANCE(I_IMBALANCE),
  .I_CLOCK_LOSS(I_CLOCK_LOSS), .I_OC_LIMIT(I_OC_LIMIT),
  .I_OC_LOW_Z(I_OC_LOW_Z), .I_WINDOW_SHORT(I_WINDOW_SHORT),
  .I_TEMP_WARN(I_TEMP_WARN), .O_POWER_EN(O_POWER_EN),
  .O_CAP_DISCHARGE(O_CAP_DISCHARGE),
  .O_THERMAL_WARNING_OE(O_THERMAL_WARNING_OE),
  .O_FAULT_STATUS_OE(O_FAULT_STATUS_OE));

/* dv/aps_controller.sv */
// model of the system controller on the mode and diagnostic pins
`timescale 1ns/100ps
module aps_controller (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // mode wanted by the sequence
  input wire logic [1:0] i_mode_req,
  // diagnostic pin drivers
  input wire logic i_warn_out,
  input wire logic i_warn_oe,
  input wire logic i_fault_out,
  input wire logic i_fault_oe,
  // mode pin and wire levels
  output logic [1:0] o_mode,
  output logic o_warn_pin,
  output logic o_fault_pin
);
  // ======
  // pulled-up wires: high unless the supervisor pulls low
  assign o_warn_pin = i_warn_oe ? i_warn_out : 1'b1;
  assign o_fault_pin = i_fault_oe ? i_fault_out : 1'b1;
  // ======
  // one of four modes
  // mode is not synchronised inside, so it moves only on an edge
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_mode <= aps_pkg::MODE_STANDBY;
    else
      o_mode <= i_mode_req;
  end
endmodule

/* dv/testbench.sv */
// self-checking bench for the amplifier protection supervisor
`timescale 1ns/100ps
module testbench;
  localparam int R = 50;
  logic clk, rst_n = 1'b0, ce = 1'b1;
  logic [1:0] mode_req = aps_pkg::MODE_STANDBY;
  logic [1:0] mode;
  logic [4:0] hard = 5'h0;
  logic oc_lim = 1'b0, low_z = 1'b0, win = 1'b0, warn = 1'b0, fold = 1'b0;
  logic pwr, mute, fold_en, cap, irq, warn_oe, fault_oe;
  logic warn_out, fault_out, warn_pin, fault_pin;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0, rd = 1'b0;
  logic [31:0] rdata;
  int err_total = 0;
  int cmp_count = 0;
  // rows: hard fault inputs beside the event bits they set
  logic [12:0] rows [5] = '{13'h101, 13'h202, 13'h404, 13'h808, 13'h1010};
  aps_top #(.RESTART_CYCLES(aps_pkg::TMR_W'(R))) aps_top_i (
    .I_CORE_CLK(clk), .I_RST_N(rst_n), .I_CE(ce), .I_MODE(mode),
    .I_OVERTEMP(hard[0]), .I_UNDERVOLT(hard[1]), .I_OVERVOLT(hard[2]),
    .I_IMBALANCE(hard[3]), .I_CLOCK_LOSS(hard[4]), .I_OC_LIMIT(oc_lim),
    .I_OC_LOW_Z(low_z), .I_WINDOW_SHORT(win), .I_TEMP_WARN(warn),
    .I_TEMP_FOLD(fold), .O_POWER_EN(pwr), .O_MUTE(mute),
    .O_FOLDBACK_EN(fold_en), .O_CAP_DISCHARGE(cap),
    .I_THERMAL_WARNING(warn_pin), .O_THERMAL_WARNING(warn_out),
    .O_THERMAL_WARNING_OE(warn_oe), .I_FAULT_STATUS(fault_pin),
    .O_FAULT_STATUS(fault_out), .O_FAULT_STATUS_OE(fault_oe),
    .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
    .O_RDATA(rdata), .O_IRQ(irq));
  aps_controller aps_controller_i (
    .i_clk(clk), .i_rst_n(rst_n), .i_mode_req(mode_req),
    .i_warn_out(warn_out), .i_warn_oe(warn_oe), .i_fault_out(fault_out),
    .i_fault_oe(fault_oe), .o_mode(mode), .o_warn_pin(warn_pin),
    .o_fault_pin(fault_pin));
  // ======
  // helpers
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string s, input logic [31:0] e,
    input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      $display("BAD %s exp %h got %h", s, e, g);
      err_total++;
    end
  endtask
  task automatic st(input logic p, input logic f);
    chk("power", {31'h0, p}, {31'h0, pwr});
    chk("fault pin", {31'h0, f}, {31'h0, fault_pin});
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [31:0] e,
    input string s);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(s, e, rdata);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ======
  // clock and watchdog
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial
  begin
    #20000;
    err_total++;
    final_report;
  end
  // ======
  // sequence
  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(aps_pkg::ADDR_MASK, {24'h0, aps_pkg::MASK_RESET}, "mask");
    rd_reg(4'h2, 32'h0, "unmapped");
    wr_reg(4'h2, 32'hffff_ffff);
    rd_reg(aps_pkg::ADDR_CTRL, aps_pkg::CTRL_RESET, "ctrl");
    // unmask the hard fault events so each row can see the interrupt
    wr_reg(aps_pkg::ADDR_MASK, 32'h1f);
    @(posedge clk) mode_req <= aps_pkg::MODE_OPERATE;
    cyc(20);
    st(1'b1, 1'b1);
    chk("mute", 32'h0, {31'h0, mute});
    foreach (rows[k])
    begin
      @(posedge clk) hard <= rows[k][12:8];
      cyc(8);
      st(1'b0, 1'b0);
      chk("irq", 32'h1, {31'h0, irq});
      rd_reg(aps_pkg::ADDR_EVENT, {24'h0, rows[k][7:0]}, "event");
      @(posedge clk) hard <= 5'h0;
      cyc(R);
      st(1'b0, 1'b0);
      cyc(10);
      st(1'b1, 1'b1);
      wr_reg(aps_pkg::ADDR_EVENT, {24'h0, rows[k][7:0]});
      rd_reg(aps_pkg::ADDR_EVENT, 32'h0, "event clear");
      chk("irq", 32'h0, {31'h0, irq});
    end
    // second fault while waiting must restart the delay
    @(posedge clk) hard <= 5'h02;
    cyc(8);
    @(posedge clk) hard <= 5'h0;
    cyc(25);
    @(posedge clk) hard <= 5'h04;
    cyc(4);
    @(posedge clk) hard <= 5'h0;
    cyc(R - 5);
    st(1'b0, 1'b0);
    cyc(15);
    st(1'b1, 1'b1);
    wr_reg(aps_pkg::ADDR_EVENT, 32'h6);
    // shorted output while leaving standby
    @(posedge clk) mode_req <= aps_pkg::MODE_STANDBY;
    @(posedge clk) win <= 1'b1;
    cyc(6);
    chk("standby power", 32'h0, {31'h0, pwr});
    @(posedge clk) mode_req <= aps_pkg::MODE_MUTE;
    cyc(20);
    st(1'b0, 1'b0);
    rd_reg(aps_pkg::ADDR_EVENT, 32'h40, "window event");
    @(posedge clk) win <= 1'b0;
    cyc(8);
    st(1'b1, 1'b1);
    chk("mute", 32'h1, {31'h0, mute});
    wr_reg(aps_pkg::ADDR_EVENT, 32'h40);
    // limiting, then low impedance drain and restart into a short
    @(posedge clk) mode_req <= aps_pkg::MODE_OPERATE;
    cyc(10);
    @(posedge clk) oc_lim <= 1'b1;
    cyc(100);
    chk("limit power", 32'h1, {31'h0, pwr});
    chk("cap", 32'h0, {31'h0, cap});
    chk("limit flag", 32'h0, {31'h0, fault_pin});
    @(posedge clk) low_z <= 1'b1;
    cyc(20);
    chk("cap", 32'h1, {31'h0, cap});
    cyc(60);
    st(1'b0, 1'b0);
    @(posedge clk) oc_lim <= 1'b0;
    low_z <= 1'b0;
    win <= 1'b1;
    cyc(R + 20);
    st(1'b0, 1'b0);
    rd_reg(aps_pkg::ADDR_EVENT, 32'h60, "oc event");
    @(posedge clk) win <= 1'b0;
    cyc(8);
    st(1'b1, 1'b1);
    wr_reg(aps_pkg::ADDR_EVENT, 32'h60);
    // warning, foldback and a masked event
    wr_reg(aps_pkg::ADDR_MASK, 32'h7f);
    @(posedge clk) warn <= 1'b1;
    cyc(6);
    chk("warn pin", 32'h0, {31'h0, warn_pin});
    @(posedge clk) fold <= 1'b1;
    cyc(6);
    st(1'b1, 1'b1);
    chk("fold", 32'h1, {31'h0, fold_en});
    chk("irq masked", 32'h0, {31'h0, irq});
    @(posedge clk) mode_req <= aps_pkg::MODE_OPERATE_NO_FOLD;
    cyc(6);
    chk("fold", 32'h0, {31'h0, fold_en});
    chk("warn pin", 32'h0, {31'h0, warn_pin});
    rd_reg(aps_pkg::ADDR_EVENT, 32'h80, "warn event");
    wr_reg(aps_pkg::ADDR_MASK, 32'h80);
    cyc(1);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    // clock enable low must ignore a register write
    @(posedge clk) ce <= 1'b0;
    wr_reg(aps_pkg::ADDR_MASK, 32'hff);
    @(posedge clk) ce <= 1'b1;
    rd_reg(aps_pkg::ADDR_MASK, 32'h80, "frozen mask");
    @(posedge clk) warn <= 1'b0;
    fold <= 1'b0;
    cyc(6);
    chk("warn pin", 32'h1, {31'h0, warn_pin});
    // mid-run reset drops every output to idle
    @(posedge clk) rst_n <= 1'b0;
    cyc(2);
    st(1'b0, 1'b1);
    chk("reset mute", 32'h1, {31'h0, mute});
    chk("reset irq", 32'h0, {31'h0, irq});
    final_report;
  end
endmodule
